// ---- rtl/image_frame_dma_writer.sv ----
// Image frame writer: pixel FIFOs, arbiter, descriptor engine, AHB master.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`default_nettype none
// Contract
// - Preview and codec paths each cross pixels through an asynchronous FIFO.
// - Arbiter watches FIFO fill thresholds and requests bus master writes.
// - Burst length is chosen from the current FIFO fill state.
// - Bus master follows a linked descriptor list to scattered frame buffers.
// - Descriptor chaining works independently on codec and preview paths.
// - One descriptor covers one whole frame, then may load the next.
// - Descriptor words are buffer address, control word, next descriptor.
// - Bursts keep being issued until the described frame is written.
// - Control value one enables fetching descriptors from the pointer.
// - Control value three means fetch next and writeback, two low bits.
// - Next pointers are followed anywhere, including back to the first.
// - Grayscale packs four pixels per word, pixel 0 in the low byte.
module image_frame_dma_writer (
  // System clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM register slave.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pixel link on its own clock.
  input wire logic pix_clk,
  input wire image_dma_pkg::pixel_t preview_pixel,
  input wire image_dma_pkg::pixel_t codec_pixel,
  // AHB master.
  output var image_dma_pkg::ahb_out_t ahb_out,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  localparam int AW = image_dma_pkg::FIFO_AW;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [3:0] burst_len(input logic [AW:0] level,
                                           input logic [23:0] left,
                                           input logic [31:0] addr);
    logic [23:0] lvl;
    lvl = {19'h00000, level};
    if (lvl >= 24'h000008 && left >= 24'h000008 && addr[4:2] == 3'h0)
      return image_dma_pkg::BURST_LONG;
    else if (lvl >= 24'h000004 && left >= 24'h000004 && addr[3:2] == 2'h0)
      return image_dma_pkg::BURST_SHORT;
    else
      return image_dma_pkg::BURST_ONE;
  endfunction

  function automatic logic [2:0] burst_code(input logic [3:0] len);
    if (len == image_dma_pkg::BURST_LONG)
      return image_dma_pkg::HBURST_INCR8;
    else if (len == image_dma_pkg::BURST_SHORT)
      return image_dma_pkg::HBURST_INCR4;
    else
      return image_dma_pkg::HBURST_SINGLE;
  endfunction

  logic [1:0] ch_en;
  logic [1:0] fetch_en;
  logic [1:0] loaded;
  logic [1:0][31:0] desc_ptr;
  logic [1:0][31:0] fb_addr;
  logic [1:0][31:0] dctl;
  logic [1:0][31:0] dnext;
  logic [1:0][23:0] left;
  logic [23:0] frame_words;
  logic bus_error;
  logic [1:0][31:0] fifo_head;
  logic [1:0][AW:0] fifo_level;
  logic [1:0] fifo_pop;
  image_dma_pkg::eng_state_t state;
  logic cur;
  logic [3:0] addr_left;
  logic [3:0] data_left;
  logic data_ph;
  logic [1:0] pix_rst_sync;
  logic pix_rst;
  image_dma_pkg::pixel_t [1:0] pix_in;

  assign pix_in = {codec_pixel, preview_pixel};

  // Reset leaves the pixel domain only on a pixel clock edge.
  always_ff @(posedge pix_clk or posedge rst)
  begin
    if (rst)
      pix_rst_sync <= 2'h3;
    else
      pix_rst_sync <= {pix_rst_sync[0], 1'b0};
  end
  assign pix_rst = pix_rst_sync[1];

  for (genvar g = 0; g < 2; g++)
  begin : path
    logic [31:0] mem [image_dma_pkg::FIFO_DEPTH];
    logic [1:0] en_sync;
    image_dma_pkg::pixel_t pix_q;
    logic [1:0] byte_idx;
    logic [23:0] pack;
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] rgray_s1;
    logic [AW:0] rgray_s2;
    logic [AW:0] wgray_s1;
    logic [AW:0] wgray_s2;
    logic full;
    logic push;

    always_ff @(posedge pix_clk or posedge pix_rst)
    begin
      if (pix_rst)
      begin
        en_sync <= 2'h0;
        pix_q <= '0;
        rgray_s1 <= '0;
        rgray_s2 <= '0;
      end
      else
      begin
        en_sync <= {en_sync[0], ch_en[g]};
        pix_q <= pix_in[g];
        rgray_s1 <= rgray;
        rgray_s2 <= rgray_s1;
      end
    end

    assign full = wgray == {~rgray_s2[AW:AW - 1], rgray_s2[AW - 2:0]};
    assign push = en_sync[1] && pix_q.valid && !full &&
                  byte_idx == image_dma_pkg::LAST_BYTE;

    // A sensor cannot be stalled, so a word that meets a full FIFO is lost.
    always_ff @(posedge pix_clk or posedge pix_rst)
    begin
      if (pix_rst)
      begin
        byte_idx <= 2'h0;
        pack <= 24'h000000;
      end
      else if (!en_sync[1])
        byte_idx <= 2'h0;
      else if (pix_q.valid)
      begin
        if (byte_idx != image_dma_pkg::LAST_BYTE)
          pack[8 * byte_idx +: 8] <= pix_q.data;
        byte_idx <= byte_idx + 2'h1;
      end
    end

    always_ff @(posedge pix_clk)
    begin
      if (push)
        mem[wbin[AW - 1:0]] <= {pix_q.data, pack};
    end

    always_ff @(posedge pix_clk or posedge pix_rst)
    begin
      if (pix_rst)
      begin
        wbin <= '0;
        wgray <= '0;
      end
      else if (push)
      begin
        wbin <= wbin + 1'b1;
        wgray <= bin2gray(wbin + 1'b1);
      end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
      begin
        wgray_s1 <= '0;
        wgray_s2 <= '0;
        rbin <= '0;
        rgray <= '0;
      end
      else
      begin
        wgray_s1 <= wgray;
        wgray_s2 <= wgray_s1;
        if (fifo_pop[g])
        begin
          rbin <= rbin + 1'b1;
          rgray <= bin2gray(rbin + 1'b1);
        end
      end
    end

    assign fifo_level[g] = gray2bin(wgray_s2) - rbin;
    assign fifo_head[g] = mem[rbin[AW - 1:0]];
  end

  // Arbiter: the preview path wins a tie, being scanned last.
  logic sel_valid;
  logic sel_ch;
  image_dma_pkg::job_t sel_job;
  logic [3:0] sel_len;

  always_comb
  begin
    sel_valid = 1'b0;
    sel_ch = 1'b0;
    sel_job = image_dma_pkg::JOB_DESC;
    sel_len = image_dma_pkg::BURST_ONE;
    for (int c = 1; c >= 0; c--)
    begin
      if (ch_en[c] && fetch_en[c] && !loaded[c])
      begin
        sel_valid = 1'b1;
        sel_ch = c[0];
        sel_job = image_dma_pkg::JOB_DESC;
        sel_len = image_dma_pkg::DESC_WORDS;
      end
      else if (loaded[c] && left[c] == 24'h000000)
      begin
        sel_valid = 1'b1;
        sel_ch = c[0];
        sel_job = image_dma_pkg::JOB_END;
        sel_len = image_dma_pkg::BURST_ONE;
      end
      else if (loaded[c] && fifo_level[c] != '0 &&
               (fifo_level[c] >= image_dma_pkg::FIFO_THRESHOLD ||
                {19'h00000, fifo_level[c]} >= left[c]))
      begin
        sel_valid = 1'b1;
        sel_ch = c[0];
        sel_job = image_dma_pkg::JOB_BURST;
        sel_len = burst_len(fifo_level[c], left[c], fb_addr[c]);
      end
    end
  end

  logic idle;
  logic wants_wb;
  logic job_go;
  logic beat_done;
  logic last_beat;
  logic finish;
  logic finish_ch;
  logic [3:0] desc_idx;

  assign idle = state == image_dma_pkg::ENG_IDLE;
  assign wants_wb = dctl[sel_ch][image_dma_pkg::CTRL_WBACK_BIT];
  assign job_go = idle && sel_valid &&
                  (sel_job != image_dma_pkg::JOB_END || wants_wb);
  assign beat_done = !idle && hready && data_ph;
  assign last_beat = beat_done && data_left == 4'h1;
  assign finish = (idle && sel_valid && sel_job == image_dma_pkg::JOB_END &&
                   !wants_wb) ||
                  (state == image_dma_pkg::ENG_WBACK && last_beat);
  assign finish_ch = idle ? sel_ch : cur;
  assign desc_idx = image_dma_pkg::DESC_WORDS - data_left;
  assign fifo_pop[0] = state == image_dma_pkg::ENG_DATA && hready &&
                       ahb_out.htrans != image_dma_pkg::HTRANS_IDLE && !cur;
  assign fifo_pop[1] = state == image_dma_pkg::ENG_DATA && hready &&
                       ahb_out.htrans != image_dma_pkg::HTRANS_IDLE && cur;

  // Bus sequencer: addresses are pipelined one beat ahead of data.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= image_dma_pkg::ENG_IDLE;
      cur <= 1'b0;
      ahb_out <= '0;
      addr_left <= 4'h0;
      data_left <= 4'h0;
      data_ph <= 1'b0;
    end
    else if (job_go)
    begin
      cur <= sel_ch;
      addr_left <= sel_len;
      data_left <= sel_len;
      ahb_out.htrans <= image_dma_pkg::HTRANS_NONSEQ;
      ahb_out.hsize <= image_dma_pkg::HSIZE_WORD;
      case (sel_job)
        image_dma_pkg::JOB_DESC:
        begin
          state <= image_dma_pkg::ENG_DESC;
          ahb_out.haddr <= desc_ptr[sel_ch];
          ahb_out.hwrite <= 1'b0;
          ahb_out.hburst <= image_dma_pkg::HBURST_INCR;
        end
        image_dma_pkg::JOB_BURST:
        begin
          state <= image_dma_pkg::ENG_DATA;
          ahb_out.haddr <= fb_addr[sel_ch];
          ahb_out.hwrite <= 1'b1;
          ahb_out.hburst <= burst_code(sel_len);
        end
        default:
        begin
          state <= image_dma_pkg::ENG_WBACK;
          ahb_out.haddr <= desc_ptr[sel_ch] + image_dma_pkg::WORD_STEP;
          ahb_out.hwrite <= 1'b1;
          ahb_out.hburst <= image_dma_pkg::HBURST_SINGLE;
        end
      endcase
    end
    else if (!idle && hready)
    begin
      data_ph <= ahb_out.htrans != image_dma_pkg::HTRANS_IDLE;
      if (ahb_out.htrans != image_dma_pkg::HTRANS_IDLE)
      begin
        if (state == image_dma_pkg::ENG_DATA)
          ahb_out.hwdata <= fifo_head[cur];
        else if (state == image_dma_pkg::ENG_WBACK)
          ahb_out.hwdata <= dctl[cur] |
                            (32'h00000001 << image_dma_pkg::CTRL_DONE_BIT);
        addr_left <= addr_left - 4'h1;
        if (addr_left > 4'h1)
        begin
          ahb_out.haddr <= ahb_out.haddr + image_dma_pkg::WORD_STEP;
          ahb_out.htrans <= image_dma_pkg::HTRANS_SEQ;
        end
        else
          ahb_out.htrans <= image_dma_pkg::HTRANS_IDLE;
      end
      if (data_ph)
        data_left <= data_left - 4'h1;
      if (last_beat)
        state <= image_dma_pkg::ENG_IDLE;
    end
  end

  // Per-channel frame context.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      fb_addr <= '0;
      dctl <= '0;
      dnext <= '0;
      left <= '0;
      loaded <= 2'h0;
    end
    else
    begin
      if (beat_done && state == image_dma_pkg::ENG_DESC)
      begin
        if (desc_idx == image_dma_pkg::DESC_ADDR_WORD)
          fb_addr[cur] <= hrdata;
        else if (desc_idx == image_dma_pkg::DESC_CTRL_WORD)
          dctl[cur] <= hrdata;
        else if (desc_idx == image_dma_pkg::DESC_NEXT_WORD)
          dnext[cur] <= hrdata;
        if (last_beat)
        begin
          loaded[cur] <= 1'b1;
          left[cur] <= frame_words;
        end
      end
      if (job_go && sel_job == image_dma_pkg::JOB_BURST)
      begin
        fb_addr[sel_ch] <= fb_addr[sel_ch] + {26'h0000000, sel_len, 2'h0};
        left[sel_ch] <= left[sel_ch] - {20'h00000, sel_len};
      end
      if (finish)
        loaded[finish_ch] <= 1'b0;
    end
  end

  // Register slave: one wait cycle, then a one-cycle acknowledge.
  logic wr_commit;
  logic [31:0] rd_val;

  assign wr_commit = avs_write && !avs_waitrequest;

  always_comb
  begin
    rd_val = image_dma_pkg::READ_IDLE;
    if (avs_address == image_dma_pkg::OFS_PREVIEW_CONTROL)
      rd_val[image_dma_pkg::CTRL_FETCH_BIT] = fetch_en[0];
    else if (avs_address == image_dma_pkg::OFS_PREVIEW_POINTER)
      rd_val = desc_ptr[0];
    else if (avs_address == image_dma_pkg::OFS_CODEC_CONTROL)
      rd_val[image_dma_pkg::CTRL_FETCH_BIT] = fetch_en[1];
    else if (avs_address == image_dma_pkg::OFS_CODEC_POINTER)
      rd_val = desc_ptr[1];
    else if (avs_address == image_dma_pkg::OFS_CHANNEL_ENABLE)
      rd_val[1:0] = ch_en;
    else if (avs_address == image_dma_pkg::OFS_FRAME_WORDS)
      rd_val[23:0] = frame_words;
    else if (avs_address == image_dma_pkg::OFS_STATUS)
    begin
      rd_val[image_dma_pkg::STAT_ENABLE_LSB +: 2] = ch_en;
      rd_val[image_dma_pkg::STAT_LOADED_LSB +: 2] = loaded;
      rd_val[image_dma_pkg::STAT_BUS_ERROR_BIT] = bus_error;
      rd_val[image_dma_pkg::STAT_STATE_LSB +: 4] = state;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= image_dma_pkg::READ_IDLE;
    end
    else if (avs_waitrequest && (avs_read || avs_write))
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_val : image_dma_pkg::READ_IDLE;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      fetch_en <= 2'h0;
      frame_words <= image_dma_pkg::FRAME_WORDS_RESET;
    end
    else if (wr_commit)
    begin
      if (avs_address == image_dma_pkg::OFS_PREVIEW_CONTROL)
        fetch_en[0] <= avs_writedata[image_dma_pkg::CTRL_FETCH_BIT];
      else if (avs_address == image_dma_pkg::OFS_CODEC_CONTROL)
        fetch_en[1] <= avs_writedata[image_dma_pkg::CTRL_FETCH_BIT];
      else if (avs_address == image_dma_pkg::OFS_FRAME_WORDS)
        frame_words <= avs_writedata[23:0];
    end
  end

  // Software writes the pointer last, so its write beats a chain step.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      desc_ptr <= {image_dma_pkg::POINTER_RESET, image_dma_pkg::POINTER_RESET};
    else
    begin
      if (finish && dctl[finish_ch][image_dma_pkg::CTRL_FETCH_BIT])
        desc_ptr[finish_ch] <= dnext[finish_ch];
      if (wr_commit && avs_address == image_dma_pkg::OFS_PREVIEW_POINTER)
        desc_ptr[0] <= avs_writedata;
      else if (wr_commit && avs_address == image_dma_pkg::OFS_CODEC_POINTER)
        desc_ptr[1] <= avs_writedata;
    end
  end

  // The stop masks only its own channel, so a stop leaves the other channel's
  // enable bit alone; an enable write in the same cycle sets the stopped bit again.
  logic stop_now;
  logic [1:0] eng_stop;

  assign stop_now = finish && !dctl[finish_ch][image_dma_pkg::CTRL_FETCH_BIT];
  assign eng_stop = stop_now ? 2'h1 << finish_ch : 2'h0;

  // A software enable arriving with a stop wins over the stop.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ch_en <= 2'h0;
    else if (wr_commit && avs_address == image_dma_pkg::OFS_CHANNEL_DISABLE)
      ch_en <= ch_en & ~eng_stop & ~avs_writedata[1:0];
    else if (wr_commit && avs_address == image_dma_pkg::OFS_CHANNEL_ENABLE)
      ch_en <= (ch_en & ~eng_stop) | avs_writedata[1:0];
    else
      ch_en <= ch_en & ~eng_stop;
  end

  // Sticky error flag; a new error wins over the clearing write.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bus_error <= 1'b0;
    else if (beat_done && hresp)
      bus_error <= 1'b1;
    else if (wr_commit && avs_address == image_dma_pkg::OFS_STATUS &&
             avs_writedata[image_dma_pkg::STAT_BUS_ERROR_BIT])
      bus_error <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- rtl/image_dma_pkg.sv ----
// Shared constants and types for the image frame writer.
`default_nettype none
package image_dma_pkg;
  // Register byte offsets on the slave bus.
  localparam logic [4:0] OFS_PREVIEW_CONTROL = 5'h00;
  localparam logic [4:0] OFS_PREVIEW_POINTER = 5'h04;
  localparam logic [4:0] OFS_CODEC_CONTROL = 5'h08;
  localparam logic [4:0] OFS_CODEC_POINTER = 5'h0C;
  localparam logic [4:0] OFS_CHANNEL_ENABLE = 5'h10;
  localparam logic [4:0] OFS_CHANNEL_DISABLE = 5'h14;
  localparam logic [4:0] OFS_FRAME_WORDS = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;
  // Control word and status field positions.
  localparam int CTRL_FETCH_BIT = 0;
  localparam int CTRL_WBACK_BIT = 1;
  localparam int CTRL_DONE_BIT = 2;
  localparam int STAT_ENABLE_LSB = 0;
  localparam int STAT_LOADED_LSB = 2;
  localparam int STAT_BUS_ERROR_BIT = 4;
  localparam int STAT_STATE_LSB = 8;
  // Reset values.
  localparam logic [31:0] POINTER_RESET = 32'h00000000;
  localparam logic [23:0] FRAME_WORDS_RESET = 24'h000100;
  localparam logic [31:0] READ_IDLE = 32'h00000000;
  // Pixel FIFO geometry and arbiter threshold.
  localparam int FIFO_AW = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_THRESHOLD = 5'h04;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  // Descriptor layout, in word order.
  localparam logic [3:0] DESC_WORDS = 4'h3;
  localparam logic [3:0] DESC_ADDR_WORD = 4'h0;
  localparam logic [3:0] DESC_CTRL_WORD = 4'h1;
  localparam logic [3:0] DESC_NEXT_WORD = 4'h2;
  localparam logic [31:0] WORD_STEP = 32'h00000004;
  // Burst lengths in words.
  localparam logic [3:0] BURST_LONG = 4'h8;
  localparam logic [3:0] BURST_SHORT = 4'h4;
  localparam logic [3:0] BURST_ONE = 4'h1;
  // AHB encodings.
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR = 3'h1;
  localparam logic [2:0] HBURST_INCR4 = 3'h3;
  localparam logic [2:0] HBURST_INCR8 = 3'h5;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pixel_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [2:0] hburst;
    logic [31:0] hwdata;
  } ahb_out_t;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_DESC = 4'b0010,
    ENG_DATA = 4'b0100,
    ENG_WBACK = 4'b1000
  } eng_state_t;

  typedef enum logic [2:0] {
    JOB_DESC = 3'b001,
    JOB_BURST = 3'b010,
    JOB_END = 3'b100
  } job_t;
endpackage
`default_nettype wire

// ---- verif/image_dma_chk.sv ----
// Concurrent checks on the image frame writer ports.
`default_nettype none
module image_dma_chk (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus.
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Bus master.
  input wire image_dma_pkg::ahb_out_t ahb_out,
  input wire logic hready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_reg_answer:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("register ack late");
  a_ack_pulse:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("register ack too long");
  a_addr_hold:
    assert property (ahb_out.htrans[1] && !hready |=> $stable(ahb_out.haddr))
      else $error("address moved in wait state");
  a_seq_step:
    assert property (ahb_out.htrans == image_dma_pkg::HTRANS_SEQ
      && $past(hready) |-> ahb_out.haddr == $past(ahb_out.haddr) + 32'h4)
      else $error("beat address not one word on");
  a_word_size:
    assert property (ahb_out.htrans[1]
      |-> ahb_out.hsize == image_dma_pkg::HSIZE_WORD)
      else $error("transfer not word sized");
  a_desc_incr:
    assert property (ahb_out.htrans == image_dma_pkg::HTRANS_NONSEQ
      && !ahb_out.hwrite |-> ahb_out.hburst == image_dma_pkg::HBURST_INCR)
      else $error("descriptor read not incrementing");
  a_burst_align:
    assert property (ahb_out.htrans == image_dma_pkg::HTRANS_NONSEQ
      && ahb_out.hburst == image_dma_pkg::HBURST_INCR8
      |-> ahb_out.haddr[4:0] == 5'h00) else $error("long burst misaligned");
  a_idle_gap:
    assert property (ahb_out.htrans == image_dma_pkg::HTRANS_NONSEQ
      && $past(hready) |-> $past(ahb_out.htrans) == image_dma_pkg::HTRANS_IDLE)
      else $error("no idle cycle between transfers");
endmodule
bind image_frame_dma_writer image_dma_chk i_image_dma_chk (.ref_clk, .rst,
  .avs_read, .avs_write, .avs_waitrequest, .ahb_out, .hready);
`default_nettype wire

// ---- verif/mem_model.sv ----
// Word memory answering the writer's bus master, with optional wait states.
`default_nettype none
module mem_model (
  // Clock.
  input wire logic ref_clk,
  // Bus master side.
  input wire image_dma_pkg::ahb_out_t ahb_out,
  input wire logic slow,
  output logic hready,
  output logic hresp,
  output logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  int rd_count [logic [31:0]];
  logic [31:0] wr_addr;
  logic wr_pend;
  initial
  begin
    hready = 1'h1;
    hrdata = 32'h0;
    wr_pend = 1'h0;
  end
  assign hresp = 1'h0;
  always @(posedge ref_clk)
  begin
    hready <= !slow || !hready;
    if (hready)
    begin
      if (wr_pend)
      begin
        mem[wr_addr] = ahb_out.hwdata;
      end
      wr_pend <= 1'h0;
      // Idle read data keeps changing so stale values never match.
      hrdata <= ~hrdata;
      if (ahb_out.htrans[1])
      begin
        wr_pend <= ahb_out.hwrite;
        wr_addr <= ahb_out.haddr;
        if (!ahb_out.hwrite)
        begin
          hrdata <= mem.exists(ahb_out.haddr) ? mem[ahb_out.haddr] : ~hrdata;
          rd_count[ahb_out.haddr]++;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/image_frame_dma_writer_tb.sv ----
// Self-checking bench for the image frame writer.
`default_nettype none
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("MISMATCH %0t got %h want %h", $time, a, b); \
    end \
  end
module image_frame_dma_writer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic pix_clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  image_dma_pkg::pixel_t preview_pixel = 9'h000;
  image_dma_pkg::pixel_t codec_pixel = 9'h000;
  image_dma_pkg::ahb_out_t ahb_out;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic slow = 1'h0;
  int bad_count = 0;
  int comparisons = 0;
  localparam logic [69:0] rows [7] = '{
    {1'h0, 5'h18, 32'h0, 32'h100},
    {1'h0, 5'h04, 32'h0, 32'h0},
    {1'h0, 5'h1C, 32'h0, 32'h100},
    {1'h1, 5'h18, 32'h8, 32'h0},
    {1'h0, 5'h18, 32'h0, 32'h8},
    {1'h1, 5'h04, 32'h30000, 32'h0},
    {1'h0, 5'h04, 32'h0, 32'h30000}};
  always #10 ref_clk = ~ref_clk;
  always #6 pix_clk = ~pix_clk;
  image_frame_dma_writer i_image_frame_dma_writer (.ref_clk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .pix_clk, .preview_pixel, .codec_pixel, .ahb_out,
    .hready, .hresp, .hrdata);
  mem_model i_mem_model (.ref_clk, .ahb_out, .slow, .hready, .hresp, .hrdata);
  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    finish_test();
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 20) give_up();
  endtask
  task automatic send(input logic cod, input logic [7:0] first);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge pix_clk);
      if (cod) codec_pixel <= {1'h1, first + 8'(i)};
      else preview_pixel <= {1'h1, first + 8'(i)};
    end
    @(posedge pix_clk);
    codec_pixel <= {1'h0, ~first};
    preview_pixel <= {1'h0, ~first};
  endtask
  task automatic frame_chk(input logic [31:0] base, input logic [7:0] first);
    logic [7:0] b;
    logic [31:0] w;
    for (int i = 0; i < 8; i++)
    begin
      b = first + 8'(4 * i);
      w = {b + 8'h3, b + 8'h2, b + 8'h1, b};
      `CHK(i_mem_model.mem[base + 32'(4 * i)], w);
    end
  endtask
  task automatic wait_mem(input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    while (!(i_mem_model.mem.exists(a) && i_mem_model.mem[a] === v)
      && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(i_mem_model.mem[a], v);
    if (n >= 4000) give_up();
  endtask
  task automatic wait_off(input int bitn);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'hFFFFFFFF;
    while (q[bitn] !== 1'h0 && n < 300)
    begin
      bus(1'h0, 5'h10, 32'h0, q);
      n++;
    end
    `CHK(q[bitn], 1'h0);
    if (n >= 300) give_up();
  endtask
  initial
  begin
    logic [31:0] q;
    i_mem_model.mem[32'h30000] = 32'h2A000;
    i_mem_model.mem[32'h30004] = 32'h3;
    i_mem_model.mem[32'h30008] = 32'h30010;
    i_mem_model.mem[32'h30010] = 32'h3A000;
    i_mem_model.mem[32'h30014] = 32'h3;
    i_mem_model.mem[32'h30018] = 32'h30000;
    i_mem_model.mem[32'h40000] = 32'h50010;
    i_mem_model.mem[32'h40004] = 32'h0;
    i_mem_model.mem[32'h40008] = 32'h44000;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    for (int i = 0; i < 7; i++)
    begin
      bus(rows[i][69], rows[i][68:64], rows[i][63:32], q);
      if (!rows[i][69]) `CHK(q, rows[i][31:0]);
    end
    bus(1'h1, 5'h00, 32'h1, q);
    bus(1'h1, 5'h10, 32'h1, q);
    // The enable needs a few pixel clocks to reach the packer.
    repeat (10) @(posedge ref_clk);
    send(1'h0, 8'h00);
    wait_mem(32'h30004, 32'h7);
    frame_chk(32'h2A000, 8'h00);
    `CHK(i_mem_model.rd_count[32'h30008], 1);
    i_mem_model.mem[32'h30004] = 32'h2;
    slow <= 1'h1;
    send(1'h0, 8'h20);
    wait_mem(32'h30014, 32'h7);
    frame_chk(32'h3A000, 8'h20);
    slow <= 1'h0;
    send(1'h0, 8'h40);
    wait_mem(32'h30004, 32'h6);
    frame_chk(32'h2A000, 8'h40);
    wait_off(0);
    bus(1'h0, 5'h04, 32'h0, q);
    `CHK(q, 32'h30000);
    bus(1'h1, 5'h08, 32'h1, q);
    bus(1'h1, 5'h0C, 32'h40000, q);
    bus(1'h1, 5'h10, 32'h2, q);
    repeat (10) @(posedge ref_clk);
    send(1'h1, 8'hA0);
    wait_mem(32'h5002C, 32'hBFBEBDBC);
    frame_chk(32'h50010, 8'hA0);
    wait_off(1);
    `CHK(i_mem_model.rd_count.exists(32'h44000), 0);
    `CHK(i_mem_model.mem[32'h40004], 32'h0);
    bus(1'h1, 5'h10, 32'h3, q);
    bus(1'h1, 5'h14, 32'h3, q);
    bus(1'h0, 5'h10, 32'h0, q);
    `CHK(q, 32'h0);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    `CHK(ahb_out, 73'h0);
    `CHK(avs_waitrequest, 1'h1);
    rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    finish_test();
  end
endmodule
`default_nettype wire
